// >>> design/afr_chan.sv
// Purpose: filter, quantize and scale one analog reference channel
// Assumes: tick is a one-cycle pulse at the sample rate
// Notes:   filter state keeps 8 fraction bits below 0.01 units
`timescale 1ns/1ps
`default_nettype none
module afr_chan #(
  parameter logic [15:0] MAX_IN = afr_pkg::VOLT_MAX
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // sample enable
  input  wire logic tick,
  // settings and results
  afr_chan_if.chan  cif
);
  // ------------------------------------------------------------------
  // two-point linear map, result clamped to +-100 %
  // ------------------------------------------------------------------
  function automatic logic signed [15:0] lin_map(
    input logic signed [15:0] x, input logic signed [15:0] xa,
    input logic signed [15:0] ya, input logic signed [15:0] xb,
    input logic signed [15:0] yb);
    logic signed [31:0] dx;
    logic signed [31:0] r;
    logic signed [31:0] full;
    // signed copy of full scale so the clamps compare signed
    full = 32'(afr_pkg::PCT_FULL);
    dx = 32'(xb) - 32'(xa);
    if (dx == 0)
      r = 32'(ya);
    else
      r = 32'(ya) + ((32'(x) - 32'(xa)) * (32'(yb) - 32'(ya))) / dx;
    if (r > full)
      r = full;
    if (r < -full)
      r = -full;
    return r[15:0];
  endfunction

  logic signed [31:0] acc_ff, nxt_acc;
  logic signed [31:0] qlv_ff, nxt_qlv;
  logic signed [15:0] mon_ff, nxt_mon;
  logic signed [15:0] pct_ff, nxt_pct;
  logic               neg_ff, nxt_neg;
  logic signed [31:0] qs;
  logic signed [15:0] qx;
  logic signed [31:0] den;

  // ------------------------------------------------------------------
  // next values: filter, hysteretic quantizer, scaling
  // ------------------------------------------------------------------
  always_comb
  begin
    nxt_mon = cif.level;
    // step in level units << 8: pct/10000 of full input
    qs = (32'(cif.step) * 32'(MAX_IN) * 32'sd256) / 32'sd10000;
    if (qs < 32'sd1)
      qs = 32'sd1;
    // signed divisor keeps falling inputs from wrapping
    den = 32'(cif.filt_ms) + 32'sd1;
    nxt_acc = acc_ff;
    nxt_qlv = qlv_ff;
    if (tick)
    begin
      // first-order recursion, 63 % after tau samples
      nxt_acc = acc_ff + ((32'(cif.level) <<< 8) - acc_ff)
                / den;
      if (acc_ff > qlv_ff + ((qs * 32'sd3) >>> 2))
        nxt_qlv = qlv_ff + qs;
      else if (acc_ff < qlv_ff - (qs >>> 2))
        nxt_qlv = qlv_ff - qs;
    end
    qx = 16'(qlv_ff >>> 8);
    if (qx < 16'sd0 && cif.bip)
      nxt_pct = lin_map(qx, cif.nx1, cif.ny1, cif.nx2, cif.ny2);
    else if (qx < 16'sd0)
      nxt_pct = 16'sd0;                          // unipolar clips
    else
      nxt_pct = lin_map(qx, cif.x1, cif.y1, cif.x2, cif.y2);
    if (nxt_pct < 16'sd0 && !cif.bip)
      nxt_pct = 16'sd0;
    nxt_neg = (nxt_pct < 16'sd0) ^ cif.inv;
  end

  // registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc_ff <= 32'sd0;
      qlv_ff <= 32'sd0;
      mon_ff <= 16'sd0;
      pct_ff <= 16'sd0;
      neg_ff <= 1'b0;
    end
    else
    begin
      acc_ff <= nxt_acc;
      qlv_ff <= nxt_qlv;
      mon_ff <= nxt_mon;
      pct_ff <= nxt_pct;
      neg_ff <= nxt_neg;
    end
  end

  assign cif.mon = mon_ff;
  assign cif.pct = pct_ff;
  assign cif.neg = neg_ff;

  // quantized level moves at most one step per sample
  AST_QSTEP: assert property (@(posedge aclk) disable iff (!aresetn)
    !tick |=> (qlv_ff == $past(qlv_ff)))
    else $error("quantizer moved without a sample");
  AST_QUP: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && acc_ff > qlv_ff + ((qs * 32'sd3) >>> 2) |=>
      qlv_ff == $past(qlv_ff) + $past(qs))
    else $error("quantizer missed a rising step");
  AST_QDN: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && acc_ff < qlv_ff - (qs >>> 2) |=>
      qlv_ff == $past(qlv_ff) - $past(qs))
    else $error("quantizer missed a falling step");
  AST_UNIPOS: assert property (@(posedge aclk) disable iff (!aresetn)
    !cif.bip && $stable(cif.bip) |=> pct_ff >= 16'sd0)
    else $error("negative percent while unipolar");
  AST_FILT: assert property (@(posedge aclk) disable iff (!aresetn)
    !tick |=> $stable(acc_ff))
    else $error("filter changed between samples");
endmodule // afr_chan
`default_nettype wire

// >>> design/afr_chan_if.sv
// Purpose: settings and results of one analog reference channel
// Assumes: settings are quasi-static register values
// Notes:   points pack {percent[31:16], level[15:0]}, both signed
`timescale 1ns/1ps
`default_nettype none
interface afr_chan_if;
  logic [15:0]        filt_ms;
  logic signed [15:0] x1, y1, x2, y2;
  logic signed [15:0] nx1, ny1, nx2, ny2;
  logic [15:0]        step;
  logic               inv;
  logic               bip;
  logic signed [15:0] level;
  logic signed [15:0] mon;
  logic signed [15:0] pct;
  logic               neg;
  modport chan (input filt_ms, x1, y1, x2, y2, nx1, ny1, nx2, ny2,
                input step, inv, bip, level, output mon, pct, neg);
  modport ctrl (output filt_ms, x1, y1, x2, y2, nx1, ny1, nx2, ny2,
                output step, inv, bip, level, input mon, pct, neg);
endinterface
`default_nettype wire

// >>> design/afr_pkg.sv
// Purpose: shared constants for the analog frequency reference block
// Assumes: 32-bit AXI4-Lite words, one register per aligned word
// Notes:   levels in 0.01 V or 0.01 mA, percent in 0.01 %, freq 0.01 Hz
package afr_pkg;
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 50;
  localparam int SAMPLE_PERIOD_NS = 1000000;  // filter step of 1 ms
  localparam int SAMPLE_CYC       = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  // ------------------------------------------------------------------
  // register word indices (byte address = 4 * index)
  // ------------------------------------------------------------------
  localparam logic [4:0] IDX_CTRL   = 5'h00;
  localparam logic [4:0] IDX_FSFREQ = 5'h01;
  localparam logic [4:0] IDX_STATUS = 5'h02;
  localparam int         CH_BASE    = 8;    // channel c at 8*(c+1)
  localparam logic [2:0] CH_FILT    = 3'h0;
  localparam logic [2:0] CH_PPT1    = 3'h1;
  localparam logic [2:0] CH_PPT2    = 3'h2;
  localparam logic [2:0] CH_NPT1    = 3'h3;
  localparam logic [2:0] CH_NPT2    = 3'h4;
  localparam logic [2:0] CH_MISC    = 3'h5;
  localparam logic [2:0] CH_MON     = 3'h6;
  localparam logic [2:0] CH_PCT     = 3'h7;
  // ------------------------------------------------------------------
  // ctrl fields
  // ------------------------------------------------------------------
  localparam int CTRL_SRC_LSB = 0;  // 2 bits: 0 main V, 1 main I, 2 opt V
  localparam int CTRL_BIP_BIT = 2;  // main voltage polarity: 1 bipolar
  localparam int MISC_INV_BIT = 16; // misc word: [15:0] step, [16] invert
  localparam logic [1:0] SRC_MAIN_V = 2'h0;
  localparam logic [1:0] SRC_MAIN_I = 2'h1;
  localparam logic [1:0] SRC_OPT_V  = 2'h2;
  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [31:0] RST_CTRL    = 32'h0000_0000;
  localparam logic [31:0] RST_FSFREQ  = 32'h0000_1770; // 60.00 Hz
  localparam logic [31:0] RST_FILT    = 32'h0000_000A; // 10 ms
  localparam logic [31:0] RST_VPT1    = 32'h0000_0000; // 0 V, 0 %
  localparam logic [31:0] RST_VPT2    = 32'h2710_03E8; // 10 V, 100 %
  localparam logic [31:0] RST_NPT1    = 32'h0000_0000; // 0 V, 0 %
  localparam logic [31:0] RST_NPT2    = 32'hD8F0_FC18; // -10 V, -100 %
  localparam logic [31:0] RST_IPT1    = 32'h0000_0190; // 4 mA, 0 %
  localparam logic [31:0] RST_IPT2    = 32'h2710_07D0; // 20 mA, 100 %
  localparam logic [31:0] RST_MISC    = 32'h0000_0004; // step 0.04 %
  localparam logic [15:0] PCT_FULL    = 16'h2710;      // 100.00 %
  localparam logic [15:0] VOLT_MAX    = 16'h03E8;      // 10.00 V
  localparam logic [15:0] CURR_MAX    = 16'h07D0;      // 20.00 mA
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// >>> design/afr_top.sv
// Purpose: analog frequency reference with AXI4-Lite register access
// Assumes: converter codes arrive as signed 0.01 V / 0.01 mA words
// Notes:   one clock; samples taken on a 1 ms enable pulse
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module afr_top #(
  parameter int SAMPLE_CYC = afr_pkg::SAMPLE_CYC
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // converter and run inputs
  input  wire logic [15:0] main_voltage_input,
  input  wire logic [15:0] main_current_input,
  input  wire logic [15:0] option_voltage_input,
  input  wire logic        option_card_present,
  input  wire logic        forward_run_command,
  input  wire logic        reverse_run_command,
  // frequency command
  output logic [15:0]      freq_cmd,
  output logic             dir_reverse,
  output logic             run_active
);
  localparam int NCH = 3;

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  logic [50:0] sy1_ff, sy2_ff;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sy1_ff <= '0;
      sy2_ff <= '0;
    end
    else
    begin
      sy1_ff <= {option_card_present, forward_run_command,
                 reverse_run_command, option_voltage_input,
                 main_current_input, main_voltage_input};
      sy2_ff <= sy1_ff;
    end
  end

  // ------------------------------------------------------------------
  // sample enable divider
  // ------------------------------------------------------------------
  logic [31:0] div_ff, nxt_div;
  logic        tick;
  always_comb
  begin
    tick    = (div_ff == 32'(SAMPLE_CYC - 1));
    nxt_div = tick ? 32'd0 : div_ff + 32'd1;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_ff <= 32'd0;
    else
      div_ff <= nxt_div;
  end

  // ------------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------------
  function automatic logic [31:0] rst_val(input logic [4:0] i);
    case (i[2:0])
      afr_pkg::CH_FILT: rst_val = afr_pkg::RST_FILT;
      afr_pkg::CH_PPT1: rst_val = (i[4:3] == 2'd2) ? afr_pkg::RST_IPT1
                                                   : afr_pkg::RST_VPT1;
      afr_pkg::CH_PPT2: rst_val = (i[4:3] == 2'd2) ? afr_pkg::RST_IPT2
                                                   : afr_pkg::RST_VPT2;
      afr_pkg::CH_NPT1: rst_val = afr_pkg::RST_NPT1;
      afr_pkg::CH_NPT2: rst_val = afr_pkg::RST_NPT2;
      afr_pkg::CH_MISC: rst_val = afr_pkg::RST_MISC;
      default:          rst_val = 32'h0000_0000;
    endcase
    if (i == afr_pkg::IDX_CTRL)
      rst_val = afr_pkg::RST_CTRL;
    if (i == afr_pkg::IDX_FSFREQ)
      rst_val = afr_pkg::RST_FSFREQ;
  endfunction

  // writable: ctrl, fsfreq and channel words 0..5
  function automatic logic is_rw(input logic [4:0] i);
    is_rw = (i == afr_pkg::IDX_CTRL) || (i == afr_pkg::IDX_FSFREQ) ||
            (i[4:3] != 2'd0 && i[2:0] <= afr_pkg::CH_MISC);
  endfunction

  logic [31:0] reg_ff [0:31];
  logic [31:0] nxt_reg [0:31];
  logic        bip;
  logic [1:0]  src;
  assign bip = reg_ff[afr_pkg::IDX_CTRL][afr_pkg::CTRL_BIP_BIT];
  assign src = reg_ff[afr_pkg::IDX_CTRL][afr_pkg::CTRL_SRC_LSB +: 2];

  // ------------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------------
  logic        bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        wr_go;
  logic [4:0]  wi, ri;
  afr_chan_if  cif [NCH] ();

  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  assign s_axi_wready  = s_axi_awready;
  assign s_axi_arready = !rvalid_ff;
  assign wr_go = s_axi_awready;
  assign wi    = s_axi_awaddr[6:2];
  assign ri    = s_axi_araddr[6:2];

  // read mux over register and channel state
  function automatic logic [31:0] rd_word(input logic [4:0] i,
    input logic [31:0] w, input logic b, input logic signed [15:0] mon,
    input logic signed [15:0] pct);
    rd_word = w;
    if (i[4:3] == 2'd1 && !b &&
        (i[2:0] == afr_pkg::CH_NPT1 || i[2:0] == afr_pkg::CH_NPT2))
      rd_word = 32'h0000_0000;
    if (i[4:3] != 2'd0 && i[2:0] == afr_pkg::CH_MON)
      rd_word = 32'(mon);
    if (i[4:3] != 2'd0 && i[2:0] == afr_pkg::CH_PCT)
      rd_word = 32'(pct);
  endfunction

  logic signed [15:0] mon_sel, pct_sel;
  always_comb
  begin
    case (ri[4:3])
      2'd1:    begin mon_sel = cif[0].mon; pct_sel = cif[0].pct; end
      2'd2:    begin mon_sel = cif[1].mon; pct_sel = cif[1].pct; end
      2'd3:    begin mon_sel = cif[2].mon; pct_sel = cif[2].pct; end
      default: begin mon_sel = 16'sd0;     pct_sel = 16'sd0;     end
    endcase
  end

  always_comb
  begin
    for (int k = 0; k < 32; k++)
      nxt_reg[k] = reg_ff[k];
    nxt_bvalid = bvalid_ff && !s_axi_bready;
    nxt_bresp  = bresp_ff;
    if (wr_go)
    begin
      nxt_bvalid = 1'b1;
      nxt_bresp  = is_rw(wi) ? afr_pkg::RESP_OKAY : afr_pkg::RESP_SLVERR;
      if (is_rw(wi))
        for (int b = 0; b < 4; b++)
          if (s_axi_wstrb[b])
            nxt_reg[wi][b*8 +: 8] = s_axi_wdata[b*8 +: 8];
    end
    nxt_rvalid = rvalid_ff && !s_axi_rready;
    nxt_rresp  = rresp_ff;
    nxt_rdata  = rdata_ff;
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = (is_rw(ri) || ri == afr_pkg::IDX_STATUS ||
                    ri[4:3] != 2'd0) ? afr_pkg::RESP_OKAY
                                     : afr_pkg::RESP_SLVERR;
      if (ri == afr_pkg::IDX_STATUS)
        nxt_rdata = {13'h0000, run_active, dir_reverse, sy2_ff[50],
                     freq_cmd};
      else if (nxt_rresp == afr_pkg::RESP_OKAY)
        nxt_rdata = rd_word(ri, reg_ff[ri], bip, mon_sel, pct_sel);
      else
        nxt_rdata = 32'h0000_0000;
    end
  end

  // bus and register flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int k = 0; k < 32; k++)
        reg_ff[k] <= rst_val(5'(k));
      bvalid_ff <= 1'b0;
      bresp_ff  <= 2'h0;
      rvalid_ff <= 1'b0;
      rresp_ff  <= 2'h0;
      rdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      for (int k = 0; k < 32; k++)
        reg_ff[k] <= nxt_reg[k];
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff  <= nxt_rresp;
      rdata_ff  <= nxt_rdata;
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp  = rresp_ff;
  assign s_axi_rdata  = rdata_ff;

  // ------------------------------------------------------------------
  // channels: 0 main voltage, 1 main current, 2 option voltage
  // ------------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    localparam int B = afr_pkg::CH_BASE * (c + 1);
    assign cif[c].filt_ms = reg_ff[B + 0][15:0];
    assign cif[c].x1   = reg_ff[B + 1][15:0];
    assign cif[c].y1   = reg_ff[B + 1][31:16];
    assign cif[c].x2   = reg_ff[B + 2][15:0];
    assign cif[c].y2   = reg_ff[B + 2][31:16];
    assign cif[c].nx1  = reg_ff[B + 3][15:0];
    assign cif[c].ny1  = reg_ff[B + 3][31:16];
    assign cif[c].nx2  = reg_ff[B + 4][15:0];
    assign cif[c].ny2  = reg_ff[B + 4][31:16];
    assign cif[c].step = reg_ff[B + 5][15:0];
    assign cif[c].inv  = reg_ff[B + 5][afr_pkg::MISC_INV_BIT];
    assign cif[c].level = sy2_ff[c*16 +: 16];
    // main voltage follows polarity; current never; option always
    assign cif[c].bip = (c == 0) ? bip : (c == 2);
    afr_chan #(
      .MAX_IN ((c == 1) ? afr_pkg::CURR_MAX : afr_pkg::VOLT_MAX)
    ) u_chan (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick),
      .cif     (cif[c])
    );
  end

  // ------------------------------------------------------------------
  // source select, direction and frequency command
  // ------------------------------------------------------------------
  logic signed [15:0] sel_pct;
  logic               sel_neg, cmd_ahead, cmd_back, card;
  logic [15:0]        mag, nxt_freq;
  logic               nxt_dir, nxt_run;
  logic [15:0]        freq_ff;
  logic               dir_ff, run_ff;
  assign card = sy2_ff[50];
  assign cmd_ahead = sy2_ff[49];
  assign cmd_back  = sy2_ff[48];
  always_comb
  begin
    case (src)
      afr_pkg::SRC_MAIN_V:
      begin
        sel_pct = cif[0].pct;
        sel_neg = cif[0].neg;
      end
      afr_pkg::SRC_MAIN_I:
      begin
        sel_pct = cif[1].pct;
        sel_neg = cif[1].neg;
      end
      afr_pkg::SRC_OPT_V:
      begin
        sel_pct = card ? cif[2].pct : 16'sd0;
        sel_neg = card && cif[2].neg;
      end
      default:
      begin
        sel_pct = 16'sd0;
        sel_neg = 1'b0;
      end
    endcase
    mag = (sel_pct < 16'sd0) ? 16'(-sel_pct) : 16'(sel_pct);
    nxt_freq = 16'((32'(mag) * 32'(reg_ff[afr_pkg::IDX_FSFREQ][15:0]))
                   / 32'(afr_pkg::PCT_FULL));
    nxt_run = cmd_ahead ^ cmd_back;
    nxt_dir = nxt_run && (cmd_back ^ sel_neg);
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      freq_ff <= 16'h0000;
      dir_ff  <= 1'b0;
      run_ff  <= 1'b0;
    end
    else
    begin
      freq_ff <= nxt_freq;
      dir_ff  <= nxt_dir;
      run_ff  <= nxt_run;
    end
  end
  assign freq_cmd    = freq_ff;
  assign dir_reverse = dir_ff;
  assign run_active  = run_ff;

  AST_FREQ: assert property (@(posedge aclk) disable iff (!aresetn)
    src == afr_pkg::SRC_MAIN_V && cif[0].pct == 16'sd10000 |=>
      freq_cmd == $past(reg_ff[afr_pkg::IDX_FSFREQ][15:0]))
    else $error("full percent does not give full-scale frequency");
  AST_DIR: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_ahead && !cmd_back && src == afr_pkg::SRC_MAIN_V |=>
      dir_reverse == $past(cif[0].neg))
    else $error("forward run direction not set by input sign");
  AST_NOCARD: assert property (@(posedge aclk) disable iff (!aresetn)
    !card && src == afr_pkg::SRC_OPT_V |=> freq_cmd == 16'h0000)
    else $error("option channel drives frequency without card");
  AST_TICK: assert property (@(posedge aclk) disable iff (!aresetn)
    tick |=> !tick)
    else $error("sample enable longer than one cycle");
endmodule // afr_top
`default_nettype wire

// >>> tb/afr_src_model.sv
// Purpose: analog source model driving converter words
// Assumes: bench sets levels in 0.01 V or 0.01 mA
// Notes:   words change after an edge, like a sampled adc
`timescale 1ns/1ps
`default_nettype none
module afr_src_model (
  // clock
  input  wire logic        aclk,
  // requested levels
  input  wire logic [15:0] set_v,
  input  wire logic [15:0] set_i,
  input  wire logic [15:0] set_o,
  // converter words
  output logic      [15:0] v_out,
  output logic      [15:0] i_out,
  output logic      [15:0] o_out
);
  // adc words follow the levels one edge later
  always_ff @(posedge aclk)
  begin
    v_out <= set_v;
    i_out <= set_i;
    o_out <= set_o;
  end
endmodule // afr_src_model
`default_nettype wire

// >>> tb/analog_frequency_reference_tb.sv
// Purpose: self-checking bench for afr_top
// Assumes: short sample period, main voltage and main current filters set to zero
// Notes:   expected values come from an integer step model
`timescale 1ns/1ps
`default_nettype none
module analog_frequency_reference_tb;
  logic        aclk, aresetn, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
  logic        ahead, back, card, dirr, runa;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd, d;
  logic [15:0] sv, si, so, v, i, o, freq;
  int          errors, n_compared, seed, q, x;
  afr_src_model src (.aclk(aclk), .set_v(sv), .set_i(si), .set_o(so),
    .v_out(v), .i_out(i), .o_out(o));
  afr_top #(.SAMPLE_CYC(20)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .main_voltage_input(v),
    .main_current_input(i), .option_voltage_input(o),
    .option_card_present(card), .forward_run_command(ahead),
    .reverse_run_command(back), .freq_cmd(freq), .dir_reverse(dirr),
    .run_active(runa));
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      errors++;
      $display("FAIL %0t saw %h want %h", $time, s, e);
    end
  endtask
  task final_report;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // a used-up wait bound counts a mismatch and ends the run
  task automatic tmo(input int n);
    if (n >= 200)
    begin
      errors++;
      final_report;
    end
  endtask
  // flags are read at each rising edge, before that edge updates them
  task automatic wr(input logic [7:0] a, input logic [31:0] w,
                    input logic [1:0] e);
    int n;
    n = 0;
    awa <= a;
    wd <= w;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    @(posedge aclk);
    while (!awr && n < 200)
    begin
      @(posedge aclk);
      n++;
    end
    tmo(n);
    awv <= 1'b0;
    wv <= 1'b0;
    n = 0;
    @(posedge aclk);
    while (!bv && n < 200)
    begin
      @(posedge aclk);
      n++;
    end
    tmo(n);
    chk(32'(bresp), 32'(e));
  endtask
  task automatic rdw(input logic [7:0] a);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    @(posedge aclk);
    while (!arr && n < 200)
    begin
      @(posedge aclk);
      n++;
    end
    tmo(n);
    arv <= 1'b0;
    n = 0;
    @(posedge aclk);
    while (!rv && n < 200)
    begin
      @(posedge aclk);
      n++;
    end
    tmo(n);
    d = rd;
    r = rresp;
  endtask
  // hysteretic quantizer: up past 3/4 step, down past 1/4 step
  function automatic int quant(int xi, int qi, int st);
    while (xi > qi + st * 3 / 4) qi += st;
    while (xi < qi - st / 4) qi -= st;
    return qi;
  endfunction
  task automatic wf(input int e);
    int n;
    n = 0;
    repeat (4) @(posedge aclk);
    while (freq !== e[15:0] && n < 3000)
    begin
      @(posedge aclk);
      n++;
    end
    chk(32'(freq), e);
    if (n >= 3000) final_report;
  endtask
  initial
  begin
    {aresetn, awv, wv, br, arv, rr, ahead, back, card} = '0;
    {awa, ara, wd, sv, si, so} = '0;
    seed = 38;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdw(8'h04);
    chk(d, 32'h0000_1770);
    rdw(8'h20);
    chk(d, 32'h0000_000A);
    rdw(8'h30);
    chk(d, 32'h0000_0000);
    rdw(8'h0C);
    chk(32'(r), 32'h0000_0002);
    wr(8'h08, 32'h0000_0000, 2'h2);
    wr(8'h04, 32'h0000_0FA0, 2'h0);
    wr(8'h20, 32'h0000_0000, 2'h0);
    wr(8'h34, 32'h0000_03E8, 2'h0);
    wr(8'h40, 32'h0000_0000, 2'h0);
    wr(8'h54, 32'h0000_03E8, 2'h0);
    wr(8'h74, 32'h0000_03E8, 2'h0);
    $display("register test done");
    ahead <= 1'b1;
    q = 0;
    repeat (8)
    begin
      x = ($random(seed) & 32'h7FF) % 1001;
      sv <= x[15:0];
      q = quant(x, q, 100);
      wf(q * 4);
      rdw(8'h38);
      chk(d[15:0], x[15:0]);
    end
    sv <= 16'h03E8;
    wf(4000);
    chk(32'(runa), 32'h0000_0001);
    $display("unipolar test done");
    wr(8'h00, 32'h0000_0004, 2'h0);
    rdw(8'h30);
    chk(d, 32'hD8F0_FC18);
    sv <= 16'h0000;
    wf(0);
    sv <= 16'hFE0C;
    wf(2000);
    rdw(8'h3C);
    chk(d[15:0], 16'hEC78);
    chk(32'(dirr), 32'h0000_0001);
    ahead <= 1'b0;
    back <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(32'(dirr), 32'h0000_0000);
    chk(32'(runa), 32'h0000_0001);
    wr(8'h34, 32'h0001_03E8, 2'h0);
    repeat (6) @(posedge aclk);
    chk(32'(dirr), 32'h0000_0001);
    $display("bipolar test done");
    wr(8'h00, 32'h0000_0001, 2'h0);
    si <= 16'd1600;
    wf(3000);
    si <= 16'd2000;
    wf(4000);
    $display("current test done");
    wr(8'h00, 32'h0000_0002, 2'h0);
    so <= 16'hFE0C;
    card <= 1'b1;
    wf(2000);
    rdw(8'h08);
    chk(d, 32'h0005_07D0);
    card <= 1'b0;
    wf(0);
    ahead <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(32'(runa), 32'h0000_0000);
    chk(32'(dirr), 32'h0000_0000);
    $display("option test done");
    final_report;
  end
endmodule // analog_frequency_reference_tb
`default_nettype wire
